// ### src/cam_mode_ctrl.sv
// mode control of the six capture/compare modules and the shared counter
//
// What this block does
// RQ1 - with pulse width output on, the wide select bit picks 8..11-bit (clear) or 16-bit (set).
// RQ2 - a module's comparator acts only while its compare enable bit is one.
// RQ3 - with rising capture enabled, every rising input edge causes a capture.
// RQ4 - with falling capture enabled, every falling input edge causes a capture.
// RQ5 - with match flag enabled, a counter match with the module value sets its event flag.
// RQ6 - with toggle enabled, a counter match inverts the module output pin.
// RQ7 - toggle and pulse width enabled together give frequency output mode.
// RQ8 - pulse width enabled drives a pulse width waveform of the selected width on the pin.
// RQ9 - an event flag requests an interrupt only while the module's mask bit is one.
// RQ10 - while the watchdog is enabled, writes to module 5 mode are ignored and it is the watchdog.
// RQ11 - software disables the watchdog before changing module 5 mode or function.
// RQ12 - the counter low byte register reads and writes counter bits 7:0.
// RQ13 - while the watchdog is enabled, writes to the counter low byte have no effect.
// RQ14 - the watchdog enable bit dedicates module 5 to the watchdog; clear leaves it off.
// RQ15 - outside 16-bit mode the cycle length code gives 8, 9, 10 (or 11) bit cycles.
// RQ16 - each enabled capture edge copies the counter into the module value and sets its flag.
// RQ17 - reset clears every mode register and the counter, so all functions start disabled.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module cam_mode_ctrl (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // module pins
   input  wire logic [5:0]  module_input_pin,
   output logic      [5:0]  module_output_pin,
   output logic      [5:0]  module_output_oe,
   // system outputs
   output logic             irq,
   output logic             wdt_expire
);
   logic [7:0]  mode_r [cam_pkg::NMOD];
   logic [15:0] cap_r  [cam_pkg::NMOD];
   logic [15:0] cnt_r;
   logic [7:0]  ctrl_r;
   logic [5:0]  flag_r;
   logic [5:0]  irq_en_r;
   logic [5:0]  pin_prev_r;
   logic [5:0]  out_r;
   logic [5:0]  oe_r;
   logic [7:0]  rdata_r;
   logic        irq_r;
   logic        wdt_exp_r;
   logic [7:0]  rdata_nxt;
   logic [5:0]  out_nxt;
   logic [5:0]  rise;
   logic [5:0]  fall;
   logic [5:0]  cap_evt;
   logic [5:0]  match;
   logic [5:0]  freq_hit;
   logic        wdt_on;
   logic        run;
   logic [15:0] pwm_mask;

   // index of a module mode register, or NMOD when the address is not one
   function automatic logic [2:0] mode_index(input logic [7:0] a);
      logic [2:0] idx;
      idx = 3'(cam_pkg::NMOD);
      if (a == cam_pkg::OFF_MODE0) idx = 3'h0;
      if (a == cam_pkg::OFF_MODE1) idx = 3'h1;
      if (a == cam_pkg::OFF_MODE2) idx = 3'h2;
      if (a == cam_pkg::OFF_MODE3) idx = 3'h3;
      if (a == cam_pkg::OFF_MODE4) idx = 3'h4;
      if (a == cam_pkg::OFF_MODE5) idx = 3'h5;
      return idx;
   endfunction

   // index inside a block of six registers starting at base, or NMOD outside it
   function automatic logic [2:0] block_index(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return (d < 8'(cam_pkg::NMOD)) ? d[2:0] : 3'(cam_pkg::NMOD);
   endfunction

   // compare mask of the pulse width cycle
   function automatic logic [15:0] cycle_mask(input logic [1:0] cls);
      case (cls)
         cam_pkg::CLS_8:  return cam_pkg::MASK_8;
         cam_pkg::CLS_9:  return cam_pkg::MASK_9;
         cam_pkg::CLS_10: return cam_pkg::MASK_10;
         default:         return cam_pkg::MASK_11;
      endcase
   endfunction

   assign wdt_on   = ctrl_r[cam_pkg::B_WDT];
   assign run      = ctrl_r[cam_pkg::B_RUN];
   // RQ15 cycle length select
   assign pwm_mask = cycle_mask(ctrl_r[cam_pkg::B_CLS_HI:cam_pkg::B_CLS_LO]);

   // RQ3 RQ4 edge detection
   assign rise = module_input_pin & ~pin_prev_r;
   assign fall = ~module_input_pin & pin_prev_r;

   always_comb begin
      for (int n = 0; n < cam_pkg::NMOD; n++) begin
         cap_evt[n]  = (mode_r[n][cam_pkg::B_RISE] & rise[n])
                     | (mode_r[n][cam_pkg::B_FALL] & fall[n]);
         // RQ2 comparator gated
         match[n]    = mode_r[n][cam_pkg::B_CMP] && (cnt_r == cap_r[n]);
         freq_hit[n] = mode_r[n][cam_pkg::B_CMP] && mode_r[n][cam_pkg::B_TOGGLE]
                     && mode_r[n][cam_pkg::B_PWM] && (cnt_r[7:0] == cap_r[n][7:0]);
      end
   end

   // pin outputs
   always_comb begin
      out_nxt = out_r;
      for (int n = 0; n < cam_pkg::NMOD; n++) begin
         if (mode_r[n][cam_pkg::B_CMP]) begin
            if (mode_r[n][cam_pkg::B_TOGGLE] && mode_r[n][cam_pkg::B_PWM]) begin
               // RQ7 frequency output
               if (freq_hit[n])
                  out_nxt[n] = ~out_r[n];
            end else if (mode_r[n][cam_pkg::B_PWM]) begin
               // RQ8 RQ1 pulse width, low below the compare value
               if (mode_r[n][cam_pkg::B_WIDE])
                  out_nxt[n] = (cnt_r >= cap_r[n]);
               else
                  out_nxt[n] = ((cnt_r & pwm_mask) >= (cap_r[n] & pwm_mask));
            end else if (mode_r[n][cam_pkg::B_TOGGLE] && match[n]) begin
               // RQ6 toggle on match
               out_nxt[n] = ~out_r[n];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_r <= cam_pkg::RST_FLAGS;
         oe_r  <= cam_pkg::RST_FLAGS;
      end else begin
         out_r <= out_nxt;
         for (int n = 0; n < cam_pkg::NMOD; n++)
            oe_r[n] <= mode_r[n][cam_pkg::B_TOGGLE] | mode_r[n][cam_pkg::B_PWM];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         pin_prev_r <= cam_pkg::RST_FLAGS;
      else
         pin_prev_r <= module_input_pin;
   end

   // RQ17 mode registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int n = 0; n < cam_pkg::NMOD; n++)
            mode_r[n] <= cam_pkg::RST_BYTE;
      end else if (reg_wr) begin
         for (int n = 0; n < cam_pkg::NMOD; n++) begin
            // RQ10 module 5 locked while the watchdog runs
            if (!(n == cam_pkg::WDT_MOD && wdt_on)) begin
               if (mode_index(reg_addr) == 3'(n))
                  mode_r[n] <= reg_wdata;
               else if (block_index(reg_addr, cam_pkg::OFF_CMP_HI) == 3'(n))
                  mode_r[n][cam_pkg::B_CMP] <= 1'b1;
            end
         end
      end
   end

   // capture/compare values; capture beats a software write in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int n = 0; n < cam_pkg::NMOD; n++)
            cap_r[n] <= cam_pkg::RST_WORD;
      end else begin
         for (int n = 0; n < cam_pkg::NMOD; n++) begin
            if (cap_evt[n])
               // RQ16 capture copy
               cap_r[n] <= cnt_r;
            else if (freq_hit[n])
               cap_r[n][7:0] <= cap_r[n][7:0] + cap_r[n][15:8];
            else if (reg_wr && block_index(reg_addr, cam_pkg::OFF_CMP_LO) == 3'(n))
               cap_r[n][7:0] <= reg_wdata;
            else if (reg_wr && block_index(reg_addr, cam_pkg::OFF_CMP_HI) == 3'(n))
               cap_r[n][15:8] <= reg_wdata;
         end
      end
   end

   // shared counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         cnt_r <= cam_pkg::RST_WORD;
      // RQ12 RQ13 low byte write, locked by the watchdog
      else if (reg_wr && reg_addr == cam_pkg::OFF_CNT_LO && !wdt_on)
         cnt_r[7:0] <= reg_wdata;
      else if (run)
         cnt_r <= cnt_r + 16'h0001;
   end

   // control: while the watchdog runs only its enable bit may change
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         ctrl_r <= cam_pkg::RST_BYTE;
      else if (reg_wr && reg_addr == cam_pkg::OFF_CTRL) begin
         // RQ14 watchdog enable
         if (wdt_on)
            ctrl_r[cam_pkg::B_WDT] <= reg_wdata[cam_pkg::B_WDT];
         else
            ctrl_r <= reg_wdata & 8'h0f;
      end
   end

   // event flags: a set in the same cycle as a clear wins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         flag_r <= cam_pkg::RST_FLAGS;
      else begin
         for (int n = 0; n < cam_pkg::NMOD; n++) begin
            // RQ5 RQ16 flag set
            if (cap_evt[n] || (match[n] && mode_r[n][cam_pkg::B_MATCH]))
               flag_r[n] <= 1'b1;
            else if (reg_wr && reg_addr == cam_pkg::OFF_IRQ_CLR && reg_wdata[n])
               flag_r[n] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         irq_en_r <= cam_pkg::RST_FLAGS;
      else if (reg_wr && reg_addr == cam_pkg::OFF_IRQ_EN)
         irq_en_r <= reg_wdata[5:0];
   end

   // RQ9 masked interrupt request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         irq_r <= 1'b0;
      else begin
         irq_r <= 1'b0;
         for (int n = 0; n < cam_pkg::NMOD; n++)
            if (flag_r[n] && irq_en_r[n] && mode_r[n][cam_pkg::B_IRQM])
               irq_r <= 1'b1;
      end
   end

   // RQ14 module 5 as watchdog: expiry when the low byte is at its top while the high byte equals its value
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         wdt_exp_r <= 1'b0;
      else
         wdt_exp_r <= wdt_on && run && cnt_r[7:0] == cam_pkg::CNT_LO_TOP
                      && cnt_r[15:8] == cap_r[cam_pkg::WDT_MOD][15:8];
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_nxt = cam_pkg::RST_BYTE;
      if (mode_index(reg_addr) != 3'(cam_pkg::NMOD))
         rdata_nxt = mode_r[mode_index(reg_addr)];
      else if (block_index(reg_addr, cam_pkg::OFF_CMP_LO) != 3'(cam_pkg::NMOD))
         rdata_nxt = cap_r[block_index(reg_addr, cam_pkg::OFF_CMP_LO)][7:0];
      else if (block_index(reg_addr, cam_pkg::OFF_CMP_HI) != 3'(cam_pkg::NMOD))
         rdata_nxt = cap_r[block_index(reg_addr, cam_pkg::OFF_CMP_HI)][15:8];
      else begin
         case (reg_addr)
            // RQ12 low byte read
            cam_pkg::OFF_CNT_LO:   rdata_nxt = cnt_r[7:0];
            cam_pkg::OFF_CNT_HI:   rdata_nxt = cnt_r[15:8];
            cam_pkg::OFF_CTRL:     rdata_nxt = ctrl_r;
            cam_pkg::OFF_IRQ_STAT: rdata_nxt = {2'h0, flag_r};
            cam_pkg::OFF_IRQ_EN:   rdata_nxt = {2'h0, irq_en_r};
            default:               rdata_nxt = cam_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         rdata_r <= cam_pkg::RST_BYTE;
      else if (reg_rd)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= cam_pkg::RST_BYTE;
   end

   assign reg_rdata         = rdata_r;
   assign module_output_pin = out_r;
   assign module_output_oe  = oe_r;
   assign irq               = irq_r;
   assign wdt_expire        = wdt_exp_r;

   // checks on the registers and pins
   AST_MODE5_LOCK: assert property (@(posedge core_clk) disable iff (rst) // RQ10
      reg_wr && reg_addr == cam_pkg::OFF_MODE5 && wdt_on |=> $stable(mode_r[cam_pkg::WDT_MOD]))
      else $error("module 5 mode changed while watchdog enabled");

   AST_CNT_LOCK: assert property (@(posedge core_clk) disable iff (rst) // RQ13
      reg_wr && reg_addr == cam_pkg::OFF_CNT_LO && wdt_on && !run |=> $stable(cnt_r))
      else $error("counter low byte written while watchdog enabled");

   // a software write beats counting, so the new low byte must stand even while running
   AST_CNT_WRITE: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      reg_wr && reg_addr == cam_pkg::OFF_CNT_LO && !wdt_on
      |=> cnt_r[7:0] == $past(reg_wdata))
      else $error("counter low byte write lost");

   AST_CNT_READ: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      reg_rd && reg_addr == cam_pkg::OFF_CNT_LO
      |=> reg_rdata == $past(cnt_r[7:0]))
      else $error("counter low byte read wrong");

   // read data must not linger, the bus has no valid qualifier
   AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      !reg_rd |=> reg_rdata == cam_pkg::RST_BYTE)
      else $error("read data outside the read cycle");

   AST_WDT_ONLY: assert property (@(posedge core_clk) disable iff (rst) // RQ14
      wdt_exp_r |-> $past(wdt_on) && $past(run)
      && $past(cnt_r[7:0]) == cam_pkg::CNT_LO_TOP)
      else $error("watchdog expiry without a running watchdog");

   AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (rst) // RQ9
      irq_r |-> $past(|(flag_r & irq_en_r)))
      else $error("interrupt without an enabled flag");

   for (genvar g = 0; g < cam_pkg::NMOD; g++) begin : g_chk
      AST_CAP_RISE: assert property (@(posedge core_clk) disable iff (rst) // RQ3
         mode_r[g][cam_pkg::B_RISE] && rise[g]
         |=> cap_r[g] == $past(cnt_r) && flag_r[g])
         else $error("rising edge capture missed");

      AST_CAP_FALL: assert property (@(posedge core_clk) disable iff (rst) // RQ4
         mode_r[g][cam_pkg::B_FALL] && fall[g]
         |=> cap_r[g] == $past(cnt_r) && flag_r[g])
         else $error("falling edge capture missed");

      AST_MATCH_FLAG: assert property (@(posedge core_clk) disable iff (rst) // RQ5
         mode_r[g][cam_pkg::B_CMP] && mode_r[g][cam_pkg::B_MATCH] && cnt_r == cap_r[g]
         |=> flag_r[g])
         else $error("match did not set the event flag");

      AST_NO_CMP: assert property (@(posedge core_clk) disable iff (rst) // RQ2
         !mode_r[g][cam_pkg::B_CMP] |=> out_r[g] == $past(out_r[g]))
         else $error("output moved with comparator disabled");

      AST_TOGGLE: assert property (@(posedge core_clk) disable iff (rst) // RQ6
         match[g] && mode_r[g][cam_pkg::B_TOGGLE] && !mode_r[g][cam_pkg::B_PWM]
         |=> out_r[g] != $past(out_r[g]))
         else $error("toggle on match missed");

      AST_PWM16: assert property (@(posedge core_clk) disable iff (rst) // RQ1
         mode_r[g][cam_pkg::B_CMP] && mode_r[g][cam_pkg::B_PWM]
         && mode_r[g][cam_pkg::B_WIDE] && !mode_r[g][cam_pkg::B_TOGGLE]
         |=> out_r[g] == ($past(cnt_r) >= $past(cap_r[g])))
         else $error("16-bit pulse width level wrong");

      AST_PWM_SHORT: assert property (@(posedge core_clk) disable iff (rst) // RQ8
         mode_r[g][cam_pkg::B_CMP] && mode_r[g][cam_pkg::B_PWM]
         && !mode_r[g][cam_pkg::B_WIDE] && !mode_r[g][cam_pkg::B_TOGGLE]
         |=> out_r[g] == (($past(cnt_r) & $past(pwm_mask))
                          >= ($past(cap_r[g]) & $past(pwm_mask))))
         else $error("short pulse width level wrong");

      // capture wins over the step, so only a plain hit is checked for the step
      AST_FREQ: assert property (@(posedge core_clk) disable iff (rst) // RQ7
         freq_hit[g] && !cap_evt[g]
         |=> out_r[g] != $past(out_r[g])
             && cap_r[g][7:0] == 8'($past(cap_r[g][7:0]) + $past(cap_r[g][15:8])))
         else $error("frequency output step missed");

      AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (rst) // RQ5
         flag_r[g] && !(reg_wr && reg_addr == cam_pkg::OFF_IRQ_CLR && reg_wdata[g])
         |=> flag_r[g])
         else $error("event flag dropped without a clear");
   end
endmodule

// ### src/cam_pkg.sv
// constants of the counter array mode control block
package cam_pkg;
   localparam int NMOD = 6;
   localparam int WDT_MOD = 5;
   // register map, byte offsets on the 8-bit register port
   localparam logic [7:0] OFF_MODE0    = 8'hda;
   localparam logic [7:0] OFF_MODE1    = 8'hdb;
   localparam logic [7:0] OFF_MODE2    = 8'hdc;
   localparam logic [7:0] OFF_MODE3    = 8'hdd;
   localparam logic [7:0] OFF_MODE4    = 8'hde;
   localparam logic [7:0] OFF_MODE5    = 8'hce;
   localparam logic [7:0] OFF_CNT_LO   = 8'hf9;
   localparam logic [7:0] OFF_CTRL     = 8'h80;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h81;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h82;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h83;
   localparam logic [7:0] OFF_CNT_HI   = 8'h84;
   localparam logic [7:0] OFF_CMP_LO   = 8'h90;
   localparam logic [7:0] OFF_CMP_HI   = 8'ha0;
   // mode register fields
   localparam int B_WIDE   = 7;
   localparam int B_CMP    = 6;
   localparam int B_RISE   = 5;
   localparam int B_FALL   = 4;
   localparam int B_MATCH  = 3;
   localparam int B_TOGGLE = 2;
   localparam int B_PWM    = 1;
   localparam int B_IRQM   = 0;
   // control register fields
   localparam int B_RUN    = 0;
   localparam int B_WDT    = 1;
   localparam int B_CLS_LO = 2;
   localparam int B_CLS_HI = 3;
   // cycle length codes
   localparam logic [1:0] CLS_8  = 2'h0;
   localparam logic [1:0] CLS_9  = 2'h1;
   localparam logic [1:0] CLS_10 = 2'h2;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [5:0]  RST_FLAGS  = 6'h00;
   localparam logic [7:0]  CNT_LO_TOP = 8'hff;
   localparam logic [15:0] MASK_8  = 16'h00ff;
   localparam logic [15:0] MASK_9  = 16'h01ff;
   localparam logic [15:0] MASK_10 = 16'h03ff;
   localparam logic [15:0] MASK_11 = 16'h07ff;
endpackage

// ### sim/cam_pad_model.sv
// pads and external circuitry around the six module pins
`timescale 1ns/10ps
module cam_pad_model (
   // clock
   input  wire logic       core_clk,
   // design side
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   output logic      [5:0] pin_in,
   // bench side
   input  wire logic [5:0] drive_lvl,
   output logic      [5:0] pad_lvl
);
   // the source changes just after an edge, so the design samples it synchronously
   always @(posedge core_clk) begin
      pin_in <= drive_lvl;
   end
   // a released pad falls to its pull-down, it never keeps the last driven value
   always_comb begin
      pad_lvl = pin_out & pin_oe;
   end
endmodule

// ### sim/counter_array_module_mode_control_tb.sv
// self-checking bench of the counter array mode control block
`timescale 1ns/10ps
module counter_array_module_mode_control_tb;
   logic       core_clk;
   logic       rst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [5:0] module_input_pin;
   logic [5:0] module_output_pin;
   logic [5:0] module_output_oe;
   logic       irq;
   logic       wdt_expire;
   logic [5:0] drive_lvl;
   logic [5:0] pad_lvl;
   int         n_errors;
   int         n_compared;
   logic [7:0] mode_off [6];

   cam_mode_ctrl dut_u (
      .core_clk          (core_clk),
      .rst               (rst),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .module_input_pin  (module_input_pin),
      .module_output_pin (module_output_pin),
      .module_output_oe  (module_output_oe),
      .irq               (irq),
      .wdt_expire        (wdt_expire)
   );

   cam_pad_model pad_u (
      .core_clk  (core_clk),
      .pin_out   (module_output_pin),
      .pin_oe    (module_output_oe),
      .pin_in    (module_input_pin),
      .drive_lvl (drive_lvl),
      .pad_lvl   (pad_lvl)
   );

   always #4 core_clk = ~core_clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // pin level, then room for the pad stage, edge detect and flag update
   task automatic pin(input logic [5:0] v);
      @(posedge core_clk);
      drive_lvl <= v;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic padc(input int i, input logic exp);
      repeat (2) @(posedge core_clk);
      #1;
      chk({7'h00, pad_lvl[i]}, {7'h00, exp});
   endtask

   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         rdc(mode_off[i], 8'h00);
         wr(mode_off[i], 8'hb1);
         rdc(mode_off[i], 8'hb1);
         wr(mode_off[i], 8'h00);
      end
      rdc(cam_pkg::OFF_CNT_LO, 8'h00);
      wr(8'h55, 8'hff);
      rdc(8'h55, 8'h00);
   endtask

   task automatic t_lock();
      wr(cam_pkg::OFF_CNT_LO, 8'h10);
      rdc(cam_pkg::OFF_CNT_LO, 8'h10);
      wr(cam_pkg::OFF_CTRL, 8'h01);
      wr(cam_pkg::OFF_CTRL, 8'h00);
      rdc(cam_pkg::OFF_CNT_LO, 8'h12);
      wr(cam_pkg::OFF_MODE5, 8'h21);
      wr(cam_pkg::OFF_CTRL, 8'h02);
      wr(cam_pkg::OFF_CNT_LO, 8'h77);
      wr(cam_pkg::OFF_MODE5, 8'h84);
      rdc(cam_pkg::OFF_CNT_LO, 8'h12);
      rdc(cam_pkg::OFF_MODE5, 8'h21);
      // software releases module 5 before touching its mode
      wr(cam_pkg::OFF_CTRL, 8'h00);
      wr(cam_pkg::OFF_MODE5, 8'h84);
      rdc(cam_pkg::OFF_MODE5, 8'h84);
      wr(cam_pkg::OFF_MODE5, 8'h00);
      wr(cam_pkg::OFF_CNT_LO, 8'h20);
   endtask

   task automatic t_capture();
      wr(cam_pkg::OFF_IRQ_EN, 8'h03);
      wr(cam_pkg::OFF_MODE0, 8'h21);
      wr(cam_pkg::OFF_MODE1, 8'h10);
      pin(6'h03);
      rdc(cam_pkg::OFF_IRQ_STAT, 8'h01);
      rdc(cam_pkg::OFF_CMP_LO, 8'h20);
      chk({7'h00, irq}, 8'h01);
      wr(cam_pkg::OFF_IRQ_CLR, 8'h01);
      wr(cam_pkg::OFF_CNT_LO, 8'h2c);
      pin(6'h00);
      rdc(cam_pkg::OFF_IRQ_STAT, 8'h02);
      rdc(cam_pkg::OFF_CMP_LO + 8'h01, 8'h2c);
      chk({7'h00, irq}, 8'h00);
      wr(cam_pkg::OFF_IRQ_CLR, 8'h03);
      wr(cam_pkg::OFF_MODE0, 8'h00);
      wr(cam_pkg::OFF_MODE1, 8'h00);
   endtask

   task automatic t_match();
      wr(cam_pkg::OFF_CMP_LO + 8'h02, 8'h2c);
      wr(cam_pkg::OFF_CMP_HI + 8'h02, 8'h00);
      wr(cam_pkg::OFF_MODE2, 8'h08);
      rdc(cam_pkg::OFF_IRQ_STAT, 8'h00);
      wr(cam_pkg::OFF_MODE2, 8'h48);
      rdc(cam_pkg::OFF_IRQ_STAT, 8'h04);
      wr(cam_pkg::OFF_MODE2, 8'h00);
      wr(cam_pkg::OFF_IRQ_CLR, 8'h04);
      // counter parked on the compare value, so the pin flips every cycle
      wr(cam_pkg::OFF_CMP_LO + 8'h03, 8'h2c);
      wr(cam_pkg::OFF_CMP_HI + 8'h03, 8'h00);
      wr(cam_pkg::OFF_MODE3, 8'h44);
      @(posedge core_clk);
      #1;
      chk({7'h00, pad_lvl[3]}, 8'h01);
      padc(3, 1'b1);
      @(posedge core_clk);
      #1;
      chk({7'h00, pad_lvl[3]}, 8'h00);
      wr(cam_pkg::OFF_MODE3, 8'h00);
   endtask

   task automatic t_pwm();
      wr(cam_pkg::OFF_CMP_LO + 8'h04, 8'h80);
      wr(cam_pkg::OFF_CMP_HI + 8'h04, 8'h01);
      wr(cam_pkg::OFF_CNT_LO, 8'h90);
      wr(cam_pkg::OFF_MODE4, 8'h42);
      padc(4, 1'b1);
      wr(cam_pkg::OFF_CNT_LO, 8'h10);
      padc(4, 1'b0);
      wr(cam_pkg::OFF_CNT_LO, 8'h90);
      wr(cam_pkg::OFF_MODE4, 8'hc2);
      padc(4, 1'b0);
      wr(cam_pkg::OFF_MODE4, 8'h42);
      padc(4, 1'b1);
      wr(cam_pkg::OFF_CTRL, 8'h04);
      padc(4, 1'b0);
      wr(cam_pkg::OFF_CTRL, 8'h00);
      padc(4, 1'b1);
      wr(cam_pkg::OFF_MODE4, 8'h00);
   endtask

   // one flip then the compare low byte steps on, so no further matches
   task automatic t_freq();
      wr(cam_pkg::OFF_CMP_LO, 8'h90);
      wr(cam_pkg::OFF_CMP_HI, 8'h05);
      wr(cam_pkg::OFF_MODE0, 8'h46);
      rdc(cam_pkg::OFF_CMP_LO, 8'h95);
      padc(0, 1'b1);
      padc(0, 1'b1);
   endtask

   // counter two short of the low byte top; expiry is one cycle wide
   task automatic t_wdt();
      wr(cam_pkg::OFF_CNT_LO, 8'hfd);
      wr(cam_pkg::OFF_CTRL, 8'h03);
      repeat (3) @(posedge core_clk);
      #1;
      chk({7'h00, wdt_expire}, 8'h01);
      @(posedge core_clk);
      #1;
      chk({7'h00, wdt_expire}, 8'h00);
      wr(cam_pkg::OFF_CTRL, 8'h01);
      wr(cam_pkg::OFF_CTRL, 8'h00);
   endtask

   task automatic close_out();
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      mode_off = '{cam_pkg::OFF_MODE0, cam_pkg::OFF_MODE1, cam_pkg::OFF_MODE2,
                   cam_pkg::OFF_MODE3, cam_pkg::OFF_MODE4, cam_pkg::OFF_MODE5};
      core_clk = 1'b0;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      drive_lvl = 6'h00;
      n_errors = 0;
      n_compared = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_lock();
      t_capture();
      t_match();
      t_pwm();
      t_freq();
      t_wdt();
      close_out();
   end

   // the scenarios need well under two thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      close_out();
   end
endmodule
